// File: src/dcf_pkg.sv
// Purpose: shared constants and helpers for the dual-clock fifo
// Assumes: depths are powers of two from 256 to 4096 words
// Notes: thresholds are word distances from the empty and full ends

package dcf_pkg;

  localparam int DCF_DATA_W = 18;
  localparam int DCF_THR_W = 12;
  localparam int DCF_DEPTH_DEF = 256;
  localparam logic [DCF_DATA_W-1:0] DCF_POP_RST = 18'h00000;
  localparam logic [DCF_THR_W-1:0] DCF_THR_D256 = 12'h01f;
  localparam logic [DCF_THR_W-1:0] DCF_THR_D512 = 12'h03f;
  localparam logic [DCF_THR_W-1:0] DCF_THR_DBIG = 12'h07f;

  // default threshold for a given depth
  function automatic logic [DCF_THR_W-1:0] dcf_thr_default(input int depth);
    logic [DCF_THR_W-1:0] v;
    v = DCF_THR_DBIG;
    if (depth == 256) begin
      v = DCF_THR_D256;
    end else if (depth == 512) begin
      v = DCF_THR_D512;
    end
    return v;
  endfunction : dcf_thr_default

endpackage : dcf_pkg

// File: src/dcf_sync.sv
// Purpose: two-flop synchroniser for a group of level bits
// Assumes: multi-bit use only for gray codes or quasi-static bits
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module dcf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : dcf_sync

`default_nettype wire

// File: src/dcf_ram.sv
// Purpose: dual-port word store, write on one clock, read by address
// Assumes: reader registers the read word in its own domain
// Notes: no reset on the array
`timescale 1ns/1ps
`default_nettype none

module dcf_ram #(
  parameter int W = 18,
  parameter int AW = 8
) (
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : dcf_ram

`default_nettype wire

// File: src/dcf_fifo.sv
// Purpose: dual-clock fifo with programmable almost flags and rewind
// Assumes: writer on core_clk, reader on pop_clk, controls synchronous to their clock
// Notes: pop_bus with pop_oe forms the three-state output
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic write_en_n,
  input wire logic threshold_access_n,
  input wire logic [DCF_DATA_W-1:0] push_bus,
  output logic full_n,
  output logic half_full_n,
  output logic almost_full_n,
  input wire logic pop_clk,
  input wire logic read_en_n,
  input wire logic output_enable_n,
  output logic [DCF_DATA_W-1:0] pop_bus,
  output logic pop_oe,
  output logic empty_n,
  output logic almost_empty_n,
  input wire logic rewind_pulse,
  input wire logic flag_sync_select_n,
  input wire logic chain_head_n
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam logic [AW:0] HALF_CNT = FULL_CNT >> 1;
  localparam logic [DCF_THR_W-1:0] THR_RST = dcf_thr_default(DEPTH);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [AW:0] from_gray(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction : from_gray

  // ------------------------------------------------------------
  // state of both domains
  // ------------------------------------------------------------
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] wgray;
    logic [DCF_THR_W-1:0] thr_ae;
    logic [DCF_THR_W-1:0] thr_af;
    logic thr_sel;
    logic thr_tgl;
    logic ae_lvl;
    logic full_n;
    logic half_n;
    logic af_n;
  } dcf_wr_t;

  typedef struct packed {
    logic [AW:0] rptr;
    logic [AW:0] rgray;
    logic [DCF_DATA_W-1:0] pop_data;
    logic pop_oe;
    logic [DCF_THR_W-1:0] thr_ae;
    logic [DCF_THR_W-1:0] thr_af;
    logic thr_sel;
    logic tgl_seen;
    logic rw_prev;
    logic af_lvl;
    logic empty_n;
    logic ae_n;
  } dcf_rd_t;

  dcf_wr_t ws;
  dcf_wr_t next_ws;
  dcf_rd_t rs;
  dcf_rd_t next_rs;

  // ------------------------------------------------------------
  // domain crossings
  // ------------------------------------------------------------
  logic [AW:0] rgray_w;
  logic [1:0] ctl_w;
  logic [AW:0] wgray_r;
  logic [6:0] ctl_r;
  logic [DCF_DATA_W-1:0] ram_q;

  dcf_sync #(.W(AW+1)) u_rptr_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d(rs.rgray),
    .q(rgray_w)
  );

  dcf_sync #(.W(2)) u_wctl_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({flag_sync_select_n, rs.af_lvl}),
    .q(ctl_w)
  );

  dcf_sync #(.W(AW+1)) u_wptr_sync (
    .clk(pop_clk),
    .rst_n(rst_n),
    .d(ws.wgray),
    .q(wgray_r)
  );

  // load and far almost-empty travel inverted so the cleared stages read as idle
  dcf_sync #(.W(7)) u_rctl_sync (
    .clk(pop_clk),
    .rst_n(rst_n),
    .d({!threshold_access_n, output_enable_n, rewind_pulse, flag_sync_select_n,
        ws.thr_tgl, !ws.ae_lvl, chain_head_n}),
    .q(ctl_r)
  );

  logic async_w;
  logic af_lvl_w;
  logic ld_r;
  logic ld_n_r;
  logic oe_n_r;
  logic rw_r;
  logic async_r;
  logic tgl_r;
  logic ae_far_n_r;
  logic head_n_r;

  assign async_w = ctl_w[1];
  assign af_lvl_w = ctl_w[0];
  assign {ld_r, oe_n_r, rw_r, async_r, tgl_r, ae_far_n_r, head_n_r} = ctl_r;
  assign ld_n_r = !ld_r;

  // ------------------------------------------------------------
  // write domain
  // ------------------------------------------------------------
  logic push;
  logic prog;
  logic [AW:0] cnt_w;
  logic [AW:0] af_dist_w;

  assign push = !write_en_n && threshold_access_n && ws.full_n;
  assign prog = !write_en_n && !threshold_access_n;
  // threshold cut or padded to the count width
  assign af_dist_w = (AW+1)'(ws.thr_af);

  dcf_ram #(.W(DCF_DATA_W), .AW(AW)) u_ram (
    .wr_clk(core_clk),
    .wr_en(push),
    .wr_addr(ws.wptr[AW-1:0]),
    .wr_data(push_bus),
    .rd_addr(rs.rptr[AW-1:0]),
    .rd_data(ram_q)
  );

  always_comb begin
    next_ws = ws;
    if (push) begin
      next_ws.wptr = ws.wptr + 1'b1;
    end
    if (prog) begin
      if (!ws.thr_sel) begin
        next_ws.thr_ae = push_bus[DCF_THR_W-1:0];
      end else begin
        next_ws.thr_af = push_bus[DCF_THR_W-1:0];
      end
      next_ws.thr_sel = !ws.thr_sel;
      next_ws.thr_tgl = !ws.thr_tgl;
    end
    next_ws.wgray = to_gray(next_ws.wptr);
    cnt_w = next_ws.wptr - from_gray(rgray_w);
    next_ws.full_n = (cnt_w != FULL_CNT);
    next_ws.half_n = !(cnt_w > HALF_CNT);
    next_ws.ae_lvl = (cnt_w <= {1'b0, ws.thr_ae});
    if (async_w) begin
      next_ws.af_n = !af_lvl_w;
    end else begin
      next_ws.af_n = !(cnt_w >= FULL_CNT - af_dist_w);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ws <= '{wptr: '0, wgray: '0, thr_ae: THR_RST, thr_af: THR_RST,
              thr_sel: 1'b0, thr_tgl: 1'b0, ae_lvl: 1'b1, full_n: 1'b1,
              half_n: 1'b1, af_n: 1'b1};
    end else begin
      ws <= next_ws;
    end
  end

  assign full_n = ws.full_n;
  assign half_full_n = ws.half_n;
  assign almost_full_n = ws.af_n;

  // ------------------------------------------------------------
  // read domain
  // ------------------------------------------------------------
  logic pop;
  logic peek;
  logic rewind;
  logic [AW:0] cnt_r;
  logic [AW:0] af_dist_r;

  assign pop = !read_en_n && ld_n_r && rs.empty_n;
  assign peek = !read_en_n && !ld_n_r;
  // the pointer jump is only safe while both sides stay idle around the pulse
  assign rewind = rw_r && !rs.rw_prev;
  assign af_dist_r = (AW+1)'(rs.thr_af);

  always_comb begin
    next_rs = rs;
    next_rs.rw_prev = rw_r;
    // thresholds are steady once the write side toggle has been seen
    if (tgl_r != rs.tgl_seen) begin
      next_rs.tgl_seen = tgl_r;
      next_rs.thr_ae = ws.thr_ae;
      next_rs.thr_af = ws.thr_af;
    end
    if (rewind) begin
      next_rs.rptr = '0;
    end else if (pop) begin
      next_rs.pop_data = ram_q;
      next_rs.rptr = rs.rptr + 1'b1;
    end else if (peek) begin
      next_rs.pop_data = rs.thr_sel ? {6'h00, rs.thr_af} : {6'h00, rs.thr_ae};
      next_rs.thr_sel = !rs.thr_sel;
    end
    next_rs.pop_oe = !oe_n_r && (!head_n_r || !read_en_n);
    next_rs.rgray = to_gray(next_rs.rptr);
    cnt_r = from_gray(wgray_r) - next_rs.rptr;
    next_rs.empty_n = (cnt_r != '0);
    next_rs.af_lvl = (cnt_r >= FULL_CNT - af_dist_r);
    if (async_r) begin
      next_rs.ae_n = ae_far_n_r;
    end else begin
      next_rs.ae_n = !(cnt_r <= {1'b0, rs.thr_ae});
    end
  end

  always_ff @(posedge pop_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs <= '{rptr: '0, rgray: '0, pop_data: DCF_POP_RST, pop_oe: 1'b0,
              thr_ae: THR_RST, thr_af: THR_RST, thr_sel: 1'b0, tgl_seen: 1'b0,
              rw_prev: 1'b0, af_lvl: 1'b0, empty_n: 1'b0, ae_n: 1'b0};
    end else begin
      rs <= next_rs;
    end
  end

  assign pop_bus = rs.pop_data;
  assign pop_oe = rs.pop_oe;
  assign empty_n = rs.empty_n;
  assign almost_empty_n = rs.ae_n;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_push_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
    push |=> ws.wptr == $past(ws.wptr) + 1'b1)
    else $error("write pointer did not advance on a write");

  a_full_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
    !full_n |=> $stable(ws.wptr))
    else $error("write taken while full");

  a_prog_empty_thr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (prog && !ws.thr_sel) |=> ws.thr_ae == $past(push_bus[DCF_THR_W-1:0]) && ws.thr_sel)
    else $error("empty threshold not loaded first");

  a_prog_sequence: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!prog && ws.thr_sel) ##1 prog |=> !ws.thr_sel && ws.thr_af == $past(push_bus[11:0]))
    else $error("threshold sequence position lost");

  a_pop_advance: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (pop && !rewind) |=> rs.rptr == $past(rs.rptr) + 1'b1 && pop_bus == $past(ram_q))
    else $error("read did not present next word");

  a_empty_holds: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (!empty_n && ld_n_r) |=> $stable(pop_bus))
    else $error("output changed while empty");

  a_rewind_start: assert property (@(posedge pop_clk) disable iff (!rst_n)
    rewind |=> rs.rptr == '0)
    else $error("rewind did not return to first location");

  a_oe_drive: assert property (@(posedge pop_clk) disable iff (!rst_n)
    oe_n_r |=> !pop_oe)
    else $error("output driven while output enable high");

  a_peek_order: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (peek && !rewind && !rs.thr_sel) |=> pop_bus[DCF_THR_W-1:0] == $past(rs.thr_ae))
    else $error("threshold readback out of order");

  a_half_on_full: assert property (@(posedge core_clk) disable iff (!rst_n)
    !full_n |-> !half_full_n)
    else $error("half-full flag high while full");

  a_empty_blocks: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (!empty_n && !rewind) |=> rs.rptr == $past(rs.rptr))
    else $error("read taken while empty");

  a_cascade_oe: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (head_n_r && read_en_n) |=> !pop_oe)
    else $error("cascaded member drove outputs without a read");

  a_ae_on_empty: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (!empty_n && !$past(async_r)) |-> !almost_empty_n)
    else $error("almost-empty flag high while empty");

  a_prog_no_push: assert property (@(posedge core_clk) disable iff (!rst_n)
    prog |=> $stable(ws.wptr))
    else $error("threshold write reached the fifo");

  a_idle_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    write_en_n |=> $stable(ws.wptr) && $stable(ws.thr_sel))
    else $error("write side changed with write enable high");

  a_peek_no_pop: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (peek && !rewind) |=> $stable(rs.rptr))
    else $error("threshold readback moved the read pointer");

  a_thr_copy: assert property (@(posedge pop_clk) disable iff (!rst_n)
    (tgl_r != rs.tgl_seen) |=>
      rs.thr_ae == $past(ws.thr_ae) && rs.thr_af == $past(ws.thr_af))
    else $error("read side threshold copy stale");

  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------
  c_full: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(full_n));
  c_drain: cover property (@(posedge pop_clk) disable iff (!rst_n) $fell(empty_n));
  c_rewind: cover property (@(posedge pop_clk) disable iff (!rst_n) rewind ##[1:20] pop);
  c_peek: cover property (@(posedge pop_clk) disable iff (!rst_n) peek ##1 peek);
  c_async: cover property (@(posedge pop_clk) disable iff (!rst_n)
    async_r && $rose(almost_empty_n));

endmodule : dcf_fifo

`default_nettype wire

// File: bench/dcf_reader.sv
// Purpose: reader-side partner that pops words from the fifo
// Assumes: pop_clk comes from the bench
// Notes: read enable changes on the falling edge of pop_clk
`timescale 1ns/1ps
`default_nettype none
module dcf_reader
  import dcf_pkg::*;
(
  input wire logic pop_clk,
  input wire logic empty_n,
  input wire logic [DCF_DATA_W-1:0] pop_wire,
  output logic read_en_n
);
  logic [DCF_DATA_W-1:0] got[$];
  initial read_en_n = 1'b1;
  // ----------------------------------------
  // pop task
  // ----------------------------------------
  // frc asks for reads even while empty
  task automatic pop(input int n, input logic frc);
    int i;
    i = 0;
    while (i < n) begin
      @(negedge pop_clk);
      read_en_n = ~(empty_n | frc);
      @(posedge pop_clk);
      if (!read_en_n) begin
        #1 got.push_back(pop_wire);
        i++;
      end
    end
    @(negedge pop_clk);
    read_en_n = 1'b1;
  endtask : pop
endmodule : dcf_reader
`default_nettype wire

// File: bench/dcf_fifo_tb_top.sv
// Purpose: self-checking bench for the dual-clock fifo
// Assumes: depth 256; starts with synchronous almost flags and standalone use, later switches to asynchronous flags and a cascaded member
// Notes: writer driven here, reader in dcf_reader
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_tb_top
  import dcf_pkg::*;
;
  typedef struct {int cnt; logic [3:0] f;} dcf_row_t;
  // f is {full_n, half_full_n, almost_full_n, almost_empty_n}
  dcf_row_t rows[9] = '{'{1, 4'he}, '{31, 4'he}, '{32, 4'hf}, '{128, 4'hf}, '{129, 4'hb},
    '{224, 4'hb}, '{225, 4'h9}, '{255, 4'h9}, '{256, 4'h1}};
  logic core_clk = 1'b0;
  logic pop_clk = 1'b0;
  logic rst_n = 1'b0;
  logic write_en_n = 1'b1;
  logic threshold_access_n = 1'b1;
  logic output_enable_n = 1'b0;
  logic rewind_pulse = 1'b0;
  logic flag_sync_select_n = 1'b0;
  logic chain_head_n = 1'b0;
  logic [DCF_DATA_W-1:0] push_bus = 18'h00000;
  logic full_n, half_full_n, almost_full_n, pop_oe, empty_n, almost_empty_n, read_en_n;
  logic [DCF_DATA_W-1:0] pop_bus;
  wire logic [DCF_DATA_W-1:0] pop_wire;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  // undriven bus shows the inverse of the last value
  assign pop_wire = pop_oe ? pop_bus : ~pop_bus;
  always #2.5 core_clk = ~core_clk;
  always #24 pop_clk = ~pop_clk;
  dcf_fifo #(.DEPTH(256)) dut (.core_clk(core_clk), .rst_n(rst_n), .write_en_n(write_en_n),
    .threshold_access_n(threshold_access_n), .push_bus(push_bus), .full_n(full_n),
    .half_full_n(half_full_n), .almost_full_n(almost_full_n), .pop_clk(pop_clk),
    .read_en_n(read_en_n), .output_enable_n(output_enable_n), .pop_bus(pop_bus),
    .pop_oe(pop_oe), .empty_n(empty_n), .almost_empty_n(almost_empty_n),
    .rewind_pulse(rewind_pulse), .flag_sync_select_n(flag_sync_select_n),
    .chain_head_n(chain_head_n));
  dcf_reader rd (.pop_clk(pop_clk), .empty_n(empty_n), .pop_wire(pop_wire),
    .read_en_n(read_en_n));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [DCF_DATA_W-1:0] g, input logic [DCF_DATA_W-1:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic pwait(input int k);
    repeat (k) @(negedge pop_clk);
  endtask : pwait
  task automatic push(input int k, input int d0);
    for (int i = 0; i < k; i++) begin
      @(negedge core_clk);
      write_en_n = 1'b0;
      push_bus = DCF_DATA_W'(d0 + i);
    end
    @(negedge core_clk);
    write_en_n = 1'b1;
  endtask : push
  task automatic do_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    pwait(6);
    chk({13'h0000, full_n, half_full_n, almost_full_n, almost_empty_n, empty_n},
      18'h0001c);
    chk(pop_bus, 18'h00000);
    @(negedge core_clk);
    rst_n = 1'b1;
    pwait(4);
    chk(pop_oe, 1'b1);
  endtask : do_reset
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    n = 0;
    foreach (rows[r]) begin
      push(rows[r].cnt - n, n);
      n = rows[r].cnt;
      pwait(6);
      chk({14'h0000, full_n, half_full_n, almost_full_n, almost_empty_n},
        {14'h0000, rows[r].f});
    end
    push(1, 'h3ffff);
    rd.pop(256, 1'b0);
    foreach (rd.got[i]) chk(rd.got[i], DCF_DATA_W'(i));
    pwait(6);
    chk(empty_n, 1'b0);
    rd.pop(1, 1'b1);
    chk(pop_wire, 18'h000ff);
    output_enable_n = 1'b1;
    pwait(4);
    chk(pop_oe, 1'b0);
    output_enable_n = 1'b0;
    do_reset();
    threshold_access_n = 1'b0;
    push(1, 'h3f005);
    threshold_access_n = 1'b1;
    pwait(5);
    threshold_access_n = 1'b0;
    push(1, 'h3f00a);
    pwait(5);
    rd.got.delete();
    rd.pop(2, 1'b1);
    chk(rd.got[0], 18'h00005);
    chk(rd.got[1], 18'h0000a);
    threshold_access_n = 1'b1;
    pwait(5);
    push(5, 'h100);
    pwait(6);
    chk(almost_empty_n, 1'b0);
    push(1, 'h105);
    pwait(6);
    chk(almost_empty_n, 1'b1);
    rd.got.delete();
    rd.pop(6, 1'b0);
    rewind_pulse = 1'b1;
    pwait(2);
    rewind_pulse = 1'b0;
    pwait(5);
    push(1, 'h106);
    rd.pop(7, 1'b0);
    foreach (rd.got[i]) chk(rd.got[i], DCF_DATA_W'('h100 + (i < 6 ? i : i - 6)));
    flag_sync_select_n = 1'b1;
    pwait(4);
    chk(almost_empty_n, 1'b0);
    push(6, 'h200);
    pwait(6);
    chk(almost_empty_n, 1'b1);
    chain_head_n = 1'b1;
    pwait(4);
    chk(pop_oe, 1'b0);
    rd.got.delete();
    rd.pop(6, 1'b0);
    foreach (rd.got[i]) chk(rd.got[i], DCF_DATA_W'('h200 + i));
    test_done();
  end
endmodule : dcf_fifo_tb_top
`default_nettype wire
